/* pkg/vcs_consts.vh */
// Notes on behaviour
// (RL1) Calibration clock is phase-detector ticks divided by the two-bit divide setting.
// (RL2) First request bit set plus update strobe starts a calibration.
// (RL3) Later calibrations start on a low-to-high change of the applied request.
// (RL4) Completion flag reads one once calibration has finished.
// (RL5) Calibration lasts 4400 calibration clock cycles.
// (RL6) Output sync held during calibration, released at its end.
// (RL7) Loop closed after adjustment and sync release.
// (RL8) Software must not set the VCO divider static during calibration.
// (RL9) Software supplies a stable reference and PLL setup before calibration.
// (RL10) Auto-load at power-up triggers a calibration after loading.
// (RL11) Rewriting PLL registers never starts a calibration by itself.
// (RL12) Software keeps the calibration clock below 6.25 MHz.
// (RL13) Software picks divide values recommended for the phase-detector rate.
// (RL14) Software recalibrates after divider or reference frequency changes.
// (RL15) Zero-delay field 01b selects internal, 11b selects external feedback.
// (RL16) Internal mode routes channel divider zero into the N divider.
// (RL17) Channel dividers one to three feed back only in external mode.
// (RL18) Feedback select field, default zero, names the feedback channel divider.
// (RL19) External mode passes the looped-back clock input to the N divider.
// (RL20) Three monitors flag references or VCO/clock input below threshold.
// (RL21) One bit picks normal or extended reference monitor thresholds.
// (RL22) Completion flag reads zero from calibration start until it finishes.
`ifndef VCS_CONSTS_VH
`define VCS_CONSTS_VH
`define VCS_CAL_CYCLES   13'h1130
`define VCS_ZD_INTERNAL  2'h1
`define VCS_ZD_EXTERNAL  2'h3
`define VCS_FB_DEFAULT   2'h0
`define VCS_CALDIV_RESET 2'h3
`define VCS_ST_IDLE      2'h0
`define VCS_ST_CAL       2'h1
`define VCS_ST_CLOSE     2'h2
`endif

/* hdl/vcs_sync2.v */
`timescale 1ns/1ps
module vcs_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rstn,
  input  wire         clk_en,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else if (clk_en) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

/* hdl/vcs_cal_div.v */
`timescale 1ns/1ps
`include "vcs_consts.vh"
module vcs_cal_div (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  input  wire       clk_en,
  // Control
  input  wire       run,
  input  wire [1:0] cal_div,
  input  wire       pd_tick,
  // Calibration clock tick
  output wire       cal_tick
);
  reg  [3:0] cnt_r;
  wire [3:0] lim;
  // Divide by 2, 4, 8 or 16
  assign lim = (4'h2 << cal_div) - 4'h1;
  assign cal_tick = run & pd_tick & (cnt_r == lim); // RL1
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_r <= 4'h0;
      end else if (pd_tick) begin
        cnt_r <= (cnt_r == lim) ? 4'h0 : cnt_r + 4'h1; // RL1
      end
    end
  end
endmodule

/* hdl/vcs_top.v */
`timescale 1ns/1ps
`include "vcs_consts.vh"
module vcs_top #(
  parameter CAL_CYCLES = `VCS_CAL_CYCLES
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  input  wire       clk_en,
  // Software configuration
  input  wire       cal_req,
  input  wire [1:0] cal_div,
  input  wire       io_update,
  input  wire [1:0] zd_mode,
  input  wire [1:0] fb_sel,
  input  wire       mon_ext_thresh,
  // Power-up auto-load
  input  wire       autoload_done,
  input  wire       autoload_cal_en,
  // Phase-detector tick (asynchronous)
  input  wire       phase_detector_edge,
  // Monitor raw comparators (asynchronous)
  input  wire       ref1_slow_norm,
  input  wire       ref1_slow_ext,
  input  wire       ref2_slow_norm,
  input  wire       ref2_slow_ext,
  input  wire       vco_slow,
  input  wire       clkin_slow,
  input  wire       clkin_selected,
  // Status and control outputs
  output reg        cal_done_r,
  output reg        cal_busy_r,
  output reg        out_sync_r,
  output reg        loop_close_r,
  output reg        fb_from_chan_r,
  output reg        fb_from_clkin_r,
  output reg  [1:0] feedback_select_mux_r,
  output reg        n_input_mux_r,
  output reg        ref1_low_r,
  output reg        ref2_low_r,
  output reg        vco_low_r
);
  reg  [1:0]  st_r;
  reg  [1:0]  st_nxt;
  reg         req_app_r;
  reg         req_seen_r;
  reg         pd_prev_r;
  reg         al_prev_r;
  reg  [12:0] cnt_r;
  reg  [1:0]  div_app_r;
  wire        pd_s;
  wire        al_s;
  wire [5:0]  mon_s;
  wire        pd_tick;
  wire        cal_tick;
  wire        start;
  wire        man_start;
  wire        auto_start;

  vcs_sync2 #(.W(2)) u_sync_ev (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .d        ({phase_detector_edge, autoload_done}),
    .q        ({pd_s, al_s})
  );

  vcs_sync2 #(.W(6)) u_sync_mon (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .d        ({ref1_slow_norm, ref1_slow_ext, ref2_slow_norm, ref2_slow_ext,
                vco_slow, clkin_slow}),
    .q        (mon_s)
  );

  vcs_cal_div u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .run      (st_r == `VCS_ST_CAL),
    .cal_div  (div_app_r),
    .pd_tick  (pd_tick),
    .cal_tick (cal_tick)
  );

  assign pd_tick    = pd_s & ~pd_prev_r;
  // Manual start only on applied request rising edge; PLL register writes do not
  assign man_start  = io_update & cal_req & ~req_app_r; // RL2 RL3 RL11
  assign auto_start = al_s & ~al_prev_r & autoload_cal_en & ~req_seen_r; // RL10
  assign start      = (man_start | auto_start) & (st_r == `VCS_ST_IDLE);

  always @* begin
    st_nxt = st_r;
    case (st_r)
      `VCS_ST_IDLE: begin
        if (start) st_nxt = `VCS_ST_CAL;
      end
      `VCS_ST_CAL: begin
        if (cal_tick && cnt_r == CAL_CYCLES - 13'h1) st_nxt = `VCS_ST_CLOSE; // RL5
      end
      `VCS_ST_CLOSE: begin
        st_nxt = `VCS_ST_IDLE;
      end
      default: begin
        st_nxt = `VCS_ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r            <= `VCS_ST_IDLE;
      req_app_r       <= 1'b0;
      req_seen_r      <= 1'b0;
      pd_prev_r       <= 1'b0;
      al_prev_r       <= 1'b0;
      cnt_r           <= 13'h0000;
      div_app_r       <= `VCS_CALDIV_RESET;
      cal_done_r      <= 1'b0;
      cal_busy_r      <= 1'b0;
      out_sync_r      <= 1'b0;
      loop_close_r    <= 1'b1;
    end else if (clk_en) begin
      st_r      <= st_nxt;
      pd_prev_r <= pd_s;
      al_prev_r <= al_s;
      if (io_update) begin
        req_app_r <= cal_req; // RL3
        if (cal_req) req_seen_r <= 1'b1;
        if (st_r == `VCS_ST_IDLE) div_app_r <= cal_div; // RL1
      end
      if (start) begin
        cnt_r        <= 13'h0000;
        cal_done_r   <= 1'b0; // RL22
        cal_busy_r   <= 1'b1;
        out_sync_r   <= 1'b1; // RL6
        loop_close_r <= 1'b0;
      end else if (st_r == `VCS_ST_CAL && cal_tick) begin
        cnt_r <= cnt_r + 13'h0001; // RL5
        if (st_nxt == `VCS_ST_CLOSE) begin
          out_sync_r <= 1'b0; // RL6
          cal_busy_r <= 1'b0;
          cal_done_r <= 1'b1; // RL4
        end
      end else if (st_r == `VCS_ST_CLOSE) begin
        loop_close_r <= 1'b1; // RL7
      end
    end
  end

  // Feedback routing and monitors
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fb_from_chan_r        <= 1'b0;
      fb_from_clkin_r       <= 1'b0;
      feedback_select_mux_r <= `VCS_FB_DEFAULT;
      n_input_mux_r         <= 1'b0;
      ref1_low_r            <= 1'b0;
      ref2_low_r            <= 1'b0;
      vco_low_r             <= 1'b0;
    end else if (clk_en) begin
      fb_from_chan_r  <= (zd_mode == `VCS_ZD_INTERNAL); // RL15 RL16
      fb_from_clkin_r <= (zd_mode == `VCS_ZD_EXTERNAL); // RL15 RL19
      n_input_mux_r   <= (zd_mode == `VCS_ZD_INTERNAL) | (zd_mode == `VCS_ZD_EXTERNAL);
      feedback_select_mux_r <= (zd_mode == `VCS_ZD_EXTERNAL) ? fb_sel
                                                              : `VCS_FB_DEFAULT; // RL17 RL18
      ref1_low_r <= mon_ext_thresh ? mon_s[4] : mon_s[5]; // RL20 RL21
      ref2_low_r <= mon_ext_thresh ? mon_s[2] : mon_s[3]; // RL20 RL21
      vco_low_r  <= clkin_selected ? mon_s[0] : mon_s[1]; // RL20
    end
  end
endmodule

/* dv/vcs_top_sva.sv */
`timescale 1ns/1ps
module vcs_chk #(
  parameter CAL_CYCLES = 4
) (
  // Clock and reset
  input wire       core_clk,
  input wire       rstn,
  // Requests
  input wire       cal_req,
  input wire       io_update,
  input wire [1:0] zd_mode,
  input wire [1:0] fb_sel,
  input wire       autoload_done,
  input wire       autoload_cal_en,
  // Watched outputs
  input wire       cal_done_r,
  input wire       cal_busy_r,
  input wire       out_sync_r,
  input wire       loop_close_r,
  input wire       fb_from_chan_r,
  input wire       fb_from_clkin_r,
  input wire [1:0] feedback_select_mux_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_end; $fell(cal_busy_r); endsequence
  sequence s_close; cal_done_r ##1 loop_close_r; endsequence
  a_start_cause: assert property ($rose(cal_busy_r) |-> $past(io_update & cal_req) || (autoload_cal_en && $past(autoload_done, 3)))
    else $error("busy rose without request");
  a_sync_busy: assert property (out_sync_r == cal_busy_r)
    else $error("sync differs from busy");
  a_done_low: assert property (cal_busy_r |-> !cal_done_r)
    else $error("done high while busy");
  a_cal_end: assert property (s_end |-> s_close)
    else $error("end of calibration wrong");
  a_loop_open: assert property (cal_busy_r |-> !loop_close_r)
    else $error("loop closed while busy");
  a_int_route: assert property ((zd_mode == 2'h1)[*3] |-> fb_from_chan_r && !fb_from_clkin_r)
    else $error("internal route wrong");
  a_int_chan: assert property ((zd_mode == 2'h1)[*3] |-> feedback_select_mux_r == 2'h0)
    else $error("internal channel not zero");
  a_ext_route: assert property ((zd_mode == 2'h3)[*3] |-> fb_from_clkin_r && !fb_from_chan_r)
    else $error("external route wrong");
  a_ext_chan: assert property ((zd_mode == 2'h3 && $stable(fb_sel))[*3] |->
    feedback_select_mux_r == fb_sel)
    else $error("external channel wrong");
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam CAL_CYCLES = 4;
  reg        core_clk = 1'b0, rstn = 1'b0, cal_req = 1'b0, io_update = 1'b0;
  reg        mon_ext_thresh = 1'b0, clkin_selected = 1'b0, phase_detector_edge = 1'b0;
  reg        ref1_slow_norm = 1'b0, ref1_slow_ext = 1'b0, ref2_slow_norm = 1'b0;
  reg        ref2_slow_ext = 1'b0, vco_slow = 1'b0, clkin_slow = 1'b0;
  reg  [1:0] cal_div = 2'h0, zd_mode = 2'h0, fb_sel = 2'h0;
  reg        autoload_done = 1'b0, autoload_cal_en = 1'b0;
  wire       cal_done_r, cal_busy_r, out_sync_r, loop_close_r, fb_from_chan_r;
  wire       fb_from_clkin_r, n_input_mux_r, ref1_low_r, ref2_low_r, vco_low_r;
  wire [1:0] feedback_select_mux_r;
  reg [15:0] seed = 16'h0041;
  integer    bad_count = 0, comparisons = 0, n, d, run_len = 0;
  integer    exp_q[$];
  vcs_top #(.CAL_CYCLES(CAL_CYCLES)) i_vcs_top (.core_clk, .rstn, .clk_en(1'b1), .cal_req,
    .cal_div, .io_update, .zd_mode, .fb_sel, .mon_ext_thresh, .autoload_done,
    .autoload_cal_en, .phase_detector_edge, .ref1_slow_norm, .ref1_slow_ext,
    .ref2_slow_norm, .ref2_slow_ext, .vco_slow, .clkin_slow, .clkin_selected, .cal_done_r,
    .cal_busy_r, .out_sync_r, .loop_close_r, .fb_from_chan_r, .fb_from_clkin_r,
    .feedback_select_mux_r, .n_input_mux_r, .ref1_low_r, .ref2_low_r, .vco_low_r);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) phase_detector_edge <= #10 ~phase_detector_edge;
  function [15:0] xs(input [15:0] s);
    reg [15:0] t;
    begin
      t = s ^ (s << 7);
      t = t ^ (t >> 9);
      xs = t ^ (t << 8);
    end
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge core_clk);
    #10;
  endtask
  task check(input [1:0] got, input [1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_len(input integer seen, input integer exp);
    comparisons++;
    if (seen < exp - 4 || seen > exp + 4) begin
      bad_count++;
      $display("unexpected busy length expected %0d seen %0d", exp, seen);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task upd(input r, input [1:0] v);
    cal_req = r;
    cal_div = v;
    io_update = 1'b1;
    tick(1);
    io_update = 1'b0;
    tick(1);
  endtask
  // Busy length per calibration, taken when busy falls
  always @(negedge core_clk) begin
    if (cal_busy_r === 1'b1) run_len = run_len + 1;
    else if (run_len > 0) begin
      chk_len(run_len, exp_q.pop_front());
      run_len = 0;
    end
  end
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    for (d = 0; d < 4; d++) begin
      if (d > 0) upd(1'b0, d[1:0]);
      upd(1'b1, d[1:0]);
      exp_q.push_back(CAL_CYCLES * (2 << d) * 2);
      check({cal_busy_r, cal_done_r}, 2'b10, "busy done");
      for (n = 0; n < 400 && cal_busy_r !== 1'b0; n++) tick(1);
      if (n == 400) begin
        bad_count++;
        wrap_up;
      end
      tick(1);
      check({cal_done_r, loop_close_r}, 2'b11, "done loop");
      upd(1'b1, 2'h2);
      tick(3);
      check({1'b0, cal_busy_r}, 2'h0, "repeat busy");
      $display("calibration test code %0d ended", d);
    end
    for (n = 0; n < 8; n++) begin
      seed = xs(seed);
      zd_mode = seed[0] ? 2'h3 : 2'h1;
      fb_sel = seed[2:1];
      tick(3);
      check({fb_from_chan_r, fb_from_clkin_r}, zd_mode[1] ? 2'b01 : 2'b10, "route");
      check(feedback_select_mux_r, zd_mode[1] ? fb_sel : 2'h0, "chan");
      check({1'b0, n_input_mux_r}, 2'h1, "n mux");
    end
    $display("feedback test ended");
    for (n = 0; n < 8; n++) begin
      seed = xs(seed);
      {ref1_slow_norm, ref1_slow_ext, ref2_slow_norm, ref2_slow_ext} = seed[3:0];
      {vco_slow, clkin_slow, clkin_selected, mon_ext_thresh} = seed[7:4];
      tick(4);
      check({ref1_low_r, ref2_low_r}, mon_ext_thresh ? {ref1_slow_ext, ref2_slow_ext} :
        {ref1_slow_norm, ref2_slow_norm}, "ref low");
      check({1'b0, vco_low_r}, {1'b0, clkin_selected ? clkin_slow : vco_slow}, "vco low");
    end
    $display("monitor test ended");
    rstn = 1'b0;
    autoload_cal_en = 1'b1;
    tick(2);
    rstn = 1'b1;
    tick(2);
    check({cal_busy_r, loop_close_r}, 2'b01, "reset state");
    autoload_done = 1'b1;
    exp_q.push_back(CAL_CYCLES * 16 * 2);
    for (n = 0; n < 400 && cal_busy_r !== 1'b1; n++) tick(1);
    for (n = n; n < 400 && cal_busy_r !== 1'b0; n++) tick(1);
    if (n == 400) begin
      bad_count++;
      wrap_up;
    end
    tick(1);
    check({cal_done_r, loop_close_r}, 2'b11, "auto done");
    $display("autoload test ended");
    wrap_up;
  end
endmodule
bind vcs_top vcs_chk #(.CAL_CYCLES(CAL_CYCLES)) i_vcs_chk (.core_clk, .rstn, .cal_req,
  .io_update, .zd_mode, .fb_sel, .autoload_done, .autoload_cal_en,
  .cal_done_r, .cal_busy_r, .out_sync_r, .loop_close_r,
  .fb_from_chan_r, .fb_from_clkin_r, .feedback_select_mux_r);
